// *** rtl/dfsc_pkg.sv ***
// package for the dynamic fan-start control register 1 block
package dfsc_pkg;
  // register offsets on the register port
  localparam logic [7:0] DFSC_CTRL1_OFFSET = 8'h36;
  localparam logic [7:0] DFSC_CTRL1_RESET  = 8'h00;
  localparam logic [7:0] DFSC_CTRL1_WMASK  = 8'hFF;
  // field positions in the control register
  localparam int DFSC_CYC_MSB_BIT   = 0;
  localparam int DFSC_GUARD_BIT     = 1;
  localparam int DFSC_R1_CAP_BIT    = 2;
  localparam int DFSC_LOC_CAP_BIT   = 3;
  localparam int DFSC_R2_CAP_BIT    = 4;
  localparam int DFSC_R1_DYN_BIT    = 5;
  localparam int DFSC_LOC_DYN_BIT   = 6;
  localparam int DFSC_R2_DYN_BIT    = 7;
  // status bit set by the low core supply event
  localparam int DFSC_STAT_LOW_BIT  = 1;

  // register port request from the serial bus engine
  typedef struct packed {
    logic       wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dfsc_req_s;

  // present temperatures of the three channels
  typedef struct packed {
    logic [7:0] remote1;
    logic [7:0] local_t;
    logic [7:0] remote2;
  } dfsc_temps_s;

  // operating-point capture strobes and data
  typedef struct packed {
    logic       remote1_we;
    logic       local_we;
    logic       remote2_we;
    logic [7:0] remote1;
    logic [7:0] local_t;
    logic [7:0] remote2;
  } dfsc_capture_s;
endpackage

// *** rtl/dfsc_ctrl1.sv ***
// dynamic fan-start control register 1 with guard and alarm capture
// Overview of operation
// R1: bit 0 is the most significant bit of the three-bit Remote 2 cycle code.
// R2: the two lower cycle-code bits come from the second control register and join bit 0.
// R3: the cycle code sets how many monitoring cycles pass between Remote 2 adjustments.
// R4: with bit 1 set and core supply below its low limit, status bit 1 is set.
// R5: the same condition raises the alert output when alerting for it is enabled.
// R6: while guarded low, processor-hot monitoring and all dynamic adjustment stop.
// R7: while guarded low, entry to shutdown is refused.
// R8: once the supply is back above the limit, monitoring, adjustment and shutdown return.
// R9: with bit 2 set, an alarm pin assertion copies Remote 1 temperature to its operating point.
// R10: with bit 2 clear, alarm assertions leave the Remote 1 operating point alone.
// R11: with bit 3 set, an alarm pin assertion copies local temperature to its operating point.
// R12: with bit 3 clear, alarm assertions leave the local operating point alone.
// R13: with bit 4 set, an alarm pin assertion copies Remote 2 temperature to its operating point.
// R14: with bit 4 clear, alarm assertions leave the Remote 2 operating point alone.
// R15: bit 1 is the enable that lets core supply govern status, alert, monitoring, adjustment and shutdown.
// R16: once the lock bit is set, writes to this register are rejected.
// R17: the three-bit Remote 2 cycle code is held as one registered value.
module dfsc_ctrl1
  import dfsc_pkg::*;
(
  // clock, reset, enable
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          clk_en,
  // register port
  input  wire dfsc_req_s     reg_req,
  output logic [7:0]         reg_rdata,
  input  wire logic          cfg_lock,
  // second control register low cycle bits
  input  wire logic [1:0]    remote2_cycle_lsbs,
  // core supply measurement and low limit
  input  wire logic [7:0]    core_supply_input,
  input  wire logic [7:0]    core_supply_low_limit,
  input  wire logic          alert_low_enable,
  // thermal alarm pin, asynchronous
  input  wire logic          thermal_alarm_pin,
  input  wire dfsc_temps_s   temps,
  // status and control outputs
  output logic               status_low_set,
  output logic               smb_alert,
  output logic               processor_hot_monitor_en,
  output logic [2:0]         dyn_adjust_en,
  output logic               shutdown_allow,
  output logic [2:0]         remote2_cycle_code,
  output dfsc_capture_s      capture
);

  logic [7:0]  ctrl;
  logic        alarm_meta;
  logic        alarm_sync;
  logic        alarm_prev;
  logic        low_prev;

  // register decode and guard condition
  wire         wr_hit  = reg_req.wr_en && (reg_req.addr == DFSC_CTRL1_OFFSET);
  wire         wr_ok   = wr_hit && !cfg_lock;                                 // R16
  wire [7:0]   next_ctrl = (ctrl & ~DFSC_CTRL1_WMASK) | (reg_req.wdata & DFSC_CTRL1_WMASK);
  wire         core_supply_low_guard = ctrl[DFSC_GUARD_BIT];                  // R15
  wire         supply_low = core_supply_low_guard
                            && (core_supply_input < core_supply_low_limit);   // R4
  wire         low_rise   = supply_low && !low_prev;
  wire         alarm_rise = alarm_sync && !alarm_prev;
  wire         remote1_alarm_capture_en = ctrl[DFSC_R1_CAP_BIT];
  wire         local_alarm_capture_en   = ctrl[DFSC_LOC_CAP_BIT];
  wire         remote2_alarm_capture_en = ctrl[DFSC_R2_CAP_BIT];
  wire         remote2_cycle_code_msb   = ctrl[DFSC_CYC_MSB_BIT];             // R1
  wire [2:0]   dyn_bits = {ctrl[DFSC_R2_DYN_BIT], ctrl[DFSC_LOC_DYN_BIT],
                           ctrl[DFSC_R1_DYN_BIT]};

  // read data is the whole register
  assign reg_rdata = ctrl;

  // control register, alarm synchroniser and edge history
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl       <= DFSC_CTRL1_RESET;
      alarm_meta <= 1'b0;
      alarm_sync <= 1'b0;
      alarm_prev <= 1'b0;
      low_prev   <= 1'b0;
    end else if (clk_en) begin
      if (wr_ok) begin
        ctrl <= next_ctrl;                                                   // R16
      end
      alarm_meta <= thermal_alarm_pin;
      alarm_sync <= alarm_meta;
      alarm_prev <= alarm_sync;
      low_prev   <= supply_low;
    end
  end

  // cycle code held coherently, status pulse and alert
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      remote2_cycle_code <= 3'h0;
      status_low_set     <= 1'b0;
      smb_alert          <= 1'b0;
    end else if (clk_en) begin
      remote2_cycle_code <= {remote2_cycle_code_msb, remote2_cycle_lsbs};     // R2 R3 R17
      status_low_set     <= low_rise;                                         // R4
      smb_alert          <= supply_low && alert_low_enable;                   // R5
    end
  end

  // guard gates monitoring, adjustment and shutdown
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      processor_hot_monitor_en <= 1'b1;
      dyn_adjust_en            <= 3'h0;
      shutdown_allow           <= 1'b1;
    end else if (clk_en) begin
      processor_hot_monitor_en <= !supply_low;                                // R6 R8
      dyn_adjust_en            <= supply_low ? 3'h0 : dyn_bits;               // R6 R8
      shutdown_allow           <= !supply_low;                                // R7 R8
    end
  end

  // capture present temperatures on alarm assertion
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      capture <= '0;
    end else if (clk_en) begin
      capture.remote1_we <= alarm_rise && remote1_alarm_capture_en;           // R9 R10
      capture.local_we   <= alarm_rise && local_alarm_capture_en;             // R11 R12
      capture.remote2_we <= alarm_rise && remote2_alarm_capture_en;           // R13 R14
      capture.remote1    <= temps.remote1;
      capture.local_t    <= temps.local_t;
      capture.remote2    <= temps.remote2;
    end
  end

  // write while locked leaves the register unchanged
  lock_hold_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // R16
    (clk_en && wr_hit && cfg_lock) |=> $stable(ctrl))                         // R16
    else $error("locked register changed");
  // unlocked write lands next cycle
  write_land_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // R16
    (clk_en && wr_ok) |=> (ctrl == $past(reg_req.wdata)))                     // R16
    else $error("write not stored");
  // cycle code msb follows bit 0
  cycle_msb_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // R1
    clk_en |=> (remote2_cycle_code[2] == $past(ctrl[DFSC_CYC_MSB_BIT])))      // R1
    else $error("cycle code msb wrong");
  // low supply with guard raises status pulse
  status_set_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // R4
    (clk_en && low_rise) |=> status_low_set)                                  // R4
    else $error("status bit not set");
  // alert follows enabled low condition
  alert_out_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // R5
    (clk_en && supply_low && alert_low_enable) |=> smb_alert)                 // R5
    else $error("alert missing");
  // guard blocks monitoring and adjustment
  guard_block_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // R6
    (clk_en && supply_low) |=> (!processor_hot_monitor_en && dyn_adjust_en == 3'h0))  // R6
    else $error("monitoring not suspended");
  // shutdown refused while low
  shutdown_block_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // R7
    (clk_en && supply_low) |=> !shutdown_allow)                               // R7
    else $error("shutdown allowed while low");
  // recovery restores shutdown
  recover_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
    (clk_en && !supply_low) |=> (shutdown_allow && processor_hot_monitor_en)) // R8
    else $error("no recovery");
  // remote 1 capture only when enabled
  remote1_cap_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // R9
    (clk_en && alarm_rise) |=> (capture.remote1_we == $past(ctrl[DFSC_R1_CAP_BIT]))) // R9
    else $error("remote 1 capture wrong");
  // local capture only when enabled
  local_cap_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
    (clk_en && alarm_rise) |=> (capture.local_we == $past(ctrl[DFSC_LOC_CAP_BIT])))  // R11
    else $error("local capture wrong");
  // remote 2 capture only when enabled
  remote2_cap_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // R13
    (clk_en && alarm_rise) |=> (capture.remote2_we == $past(ctrl[DFSC_R2_CAP_BIT]))) // R13
    else $error("remote 2 capture wrong");
  // no capture strobe without an alarm edge
  no_cap_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
    (clk_en && !alarm_rise) |=> !(capture.remote1_we || capture.local_we
                                  || capture.remote2_we))                     // R10
    else $error("capture without alarm");
  // cycle code low bits follow the second register
  cycle_lsb_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // R2
    clk_en |=> (remote2_cycle_code[1:0] == $past(remote2_cycle_lsbs)))
    else $error("cycle code low bits wrong");
  // guard bit clear leaves the supply without effect
  guard_off_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // R15
    (clk_en && !core_supply_low_guard)
      |=> (shutdown_allow && processor_hot_monitor_en && !smb_alert && !status_low_set))
    else $error("supply acted with guard off");
  // status pulse only on a new low condition
  status_pulse_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // R4
    (clk_en && !low_rise) |=> !status_low_set)
    else $error("status pulse without new low");
  // no alert while alerting is off
  alert_quiet_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // R5
    (clk_en && !alert_low_enable) |=> !smb_alert)
    else $error("alert while disabled");
  // raw low reading with guard set blocks shutdown
  low_decode_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // R7
    (clk_en && core_supply_low_guard && (core_supply_input < core_supply_low_limit))
      |=> !shutdown_allow)
    else $error("low supply not decoded");
  // reading at or above the limit restores shutdown
  recover_raw_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
    (clk_en && (core_supply_input >= core_supply_low_limit)) |=> shutdown_allow)
    else $error("shutdown not restored");
  // dynamic enables return with the register bits
  dyn_follow_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
    (clk_en && !supply_low) |=> (dyn_adjust_en == $past(dyn_bits)))
    else $error("dynamic enables not restored");
  // captured data is the temperature of the detecting cycle
  cap_data_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // R9
    (clk_en && alarm_rise)
      |=> ({capture.remote1, capture.local_t, capture.remote2} == $past(temps)))
    else $error("captured temperature wrong");
  // one remote 1 strobe per alarm assertion
  strobe_once_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // R9
    (clk_en && capture.remote1_we) |=> !capture.remote1_we)
    else $error("repeated capture strobe");
  // cleared enables keep each channel quiet
  remote1_off_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
    (clk_en && !remote1_alarm_capture_en) |=> !capture.remote1_we)
    else $error("remote 1 captured while off");
  local_off_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // R12
    (clk_en && !local_alarm_capture_en) |=> !capture.local_we)
    else $error("local captured while off");
  remote2_off_a : assert property (@(posedge sys_clk) disable iff (!rst_n) // R14
    (clk_en && !remote2_alarm_capture_en) |=> !capture.remote2_we)
    else $error("remote 2 captured while off");

endmodule

// *** dv/dfsc_host_model.sv ***
// host software model issuing register writes
module dfsc_host_model
  import dfsc_pkg::*;
(
  // clock
  input  wire logic sys_clk,
  // register port request
  output dfsc_req_s req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;
  // single-byte write held across one taking edge, then fields scrambled
  task automatic wr(input logic [7:0] a, d);
    @(posedge sys_clk);
    #2 req = '{1'b1, a, d};
    @(posedge sys_clk);
    #2 req = '{1'b0, ~a, ~d};
  endtask
endmodule

// *** dv/testbench.sv ***
// self-checking bench for dynamic fan-start control register 1
module testbench
  import dfsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rst_n = 0, lock = 0, aen = 0, pin = 0, ce = 1;
  logic [1:0] lsbs = 0;
  logic [7:0] sup = 8'hC0, lim = 8'h80, rdata, d;
  logic status, alert, mon, shut;
  logic [2:0] dyn, code;
  dfsc_temps_s temps = '0;
  dfsc_capture_s capture;
  dfsc_req_s req;
  logic [7:0] en [5] = '{8'h1C, 8'h04, 8'h08, 8'h10, 8'h00};
  int num_errors = 0, samples_checked = 0, seed = 27, i;
  logic [31:0] q [$];
  event go;
  wire [31:0] obs = {14'h0, rdata, status, alert, mon, shut, dyn, code};
  always #25 sys_clk = ~sys_clk;
  dfsc_host_model host (.sys_clk(sys_clk), .req(req));
  dfsc_ctrl1 i_dfsc_ctrl1 (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(ce), .reg_req(req),
    .reg_rdata(rdata), .cfg_lock(lock), .remote2_cycle_lsbs(lsbs), .core_supply_input(sup),
    .core_supply_low_limit(lim), .alert_low_enable(aen), .thermal_alarm_pin(pin),
    .temps(temps), .status_low_set(status), .smb_alert(alert), .processor_hot_monitor_en(mon),
    .dyn_adjust_en(dyn), .shutdown_allow(shut), .remote2_cycle_code(code), .capture(capture));
  task automatic check(input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("Error %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // expected status vector from register value and guard state
  function automatic logic [31:0] ex(input logic [7:0] v, input logic st, low);
    return {14'h0, v, st, low & aen, ~low, ~low, low ? 3'h0 : v[7:5], v[0], lsbs};
  endfunction
  task automatic note(input logic [31:0] e);
    q.push_back(e);
    ->go;
  endtask
  // watcher takes the oldest note when a result is ready
  always @(go) check(obs, q.pop_front());
  task automatic summarize();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100000 num_errors++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    #2 rst_n = 1;
    note(ex(8'h00, 0, 0));
    for (i = 0; i < 12; i++) begin
      d = 8'($random(seed));
      lsbs = 2'($random(seed));
      host.wr(8'h36, d);
      @(posedge sys_clk);
      #2 note(ex(d, 0, 0));
    end
    $display("test writes done");
    host.wr(8'h37, ~d);
    lock = 1;
    host.wr(8'h36, ~d);
    lock = 0;
    // frozen clock enable must drop a write as well
    ce = 0;
    host.wr(8'h36, ~d);
    ce = 1;
    @(posedge sys_clk);
    #2 note(ex(d, 0, 0));
    $display("test refused done");
    sup = 8'h10;
    host.wr(8'h36, 8'hE0);
    repeat (2) @(posedge sys_clk);
    #2 note(ex(8'hE0, 0, 0));
    sup = 8'h80;
    for (i = 0; i < 2; i++) begin
      aen = 1'(i);
      host.wr(8'h36, 8'hE2);
      sup = 8'h7F;
      @(posedge sys_clk);
      #2 note(ex(8'hE2, 1, 1));
      @(posedge sys_clk);
      #2 note(ex(8'hE2, 0, 1));
      sup = 8'h80;
      repeat (2) @(posedge sys_clk);
      #2 note(ex(8'hE2, 0, 0));
    end
    $display("test guard done");
    foreach (en[k]) begin
      host.wr(8'h36, en[k]);
      temps = 24'($random(seed));
      pin = 1;
      for (i = 0; i < 8; i++) begin
        @(posedge sys_clk);
        #2 if (capture[26:24] !== 3'h0) break;
      end
      check(capture[26:24], {en[k][2], en[k][3], en[k][4]});
      if (en[k] != 8'h00) check(capture[23:0], temps);
      @(posedge sys_clk);
      #2 check(capture[26:24], 3'h0);
      pin = 0;
      repeat (4) @(posedge sys_clk);
    end
    $display("test capture done");
    summarize();
  end
endmodule
